/* rtl/udmab_pkg.sv */
// Package for the Ultra DMA burst engine: constants and carrier types
package udmab_pkg;

  // ****************************************
  // Widths and CRC
  // ****************************************
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] CRC_SEED = 16'h4aba;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // ****************************************
  // Timing, in ns, and cycle counts at ref_clk_i
  // ****************************************
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned T_ZIORDY_NS = 20;
  localparam int unsigned T_RP_NS = 160;
  localparam int unsigned T_IORDYZ_NS = 20;
  localparam int unsigned ZIORDY_CYC = (T_ZIORDY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned IORDYZ_CYC_RAW = T_IORDYZ_NS / CLK_NS;
  localparam int unsigned IORDYZ_CYC = (IORDYZ_CYC_RAW < 1) ? 1 : IORDYZ_CYC_RAW;
  localparam int unsigned CNT_W = 8;

  // ****************************************
  // Types
  // ****************************************
  // Host-driven lines as seen at the device pins
  typedef struct packed {
    logic dmack_n;
    logic stop;
    logic hstrobe;
    logic [DATA_W-1:0] data;
  } udmab_host_t;

  // Word handed to the user side
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] word;
  } udmab_word_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_REQ = 6'b000010,
    ST_XFER = 6'b000100,
    ST_PAUSE = 6'b001000,
    ST_TERM = 6'b010000,
    ST_DONE = 6'b100000
  } udmab_state_t;

endpackage

/* rtl/udmab_sync.sv */
// Three-stage synchroniser with agreement filter for host pins
`timescale 1ns/1ps
`default_nettype none
module udmab_sync #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic init_r;

  // Stages hold zero in reset; the idle level is loaded once after release
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_r <= 1'b0;
      sync_o <= '0;
    end else begin
      init_r <= 1'b1;
      if (!init_r) begin
        sync_o <= rst_val_i;
      end else begin
        // Bitwise: a bit changes only once stage two and three agree
        sync_o <= (s2_r & s3_r) | (sync_o & (s2_r | s3_r));
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/udmab_engine.sv */
// Device end of an Ultra DMA data-out burst with host CRC check
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Device latches host CRC from the data bus when acknowledge negates.
// - Device compares CRCs; only the first miscompare of a command is reported.
// - Device releases its strobe/ready line shortly after acknowledge negates.
// - Device raises request while acknowledge is negated to start a burst.
// - Device drives ready negated after enable delay, keeps driving until end.
// - Device asserts ready after STOP negates; holds it until first strobe fall.
// - Burst meanings of shared lines hold only while request and acknowledge assert; the code also keeps them in device termination.
// - Device pauses only after one word, by negating ready; resumes by asserting.
// - Device accepts zero, one, two or three further words depending on timing.
// - Device absorbs up to three further words after pausing.
// - While paused device may drop request, not before ready-to-pause time.
// - Per-burst 16-bit CRC seeded 4ABAh, updated each data strobe edge.
module udmab_engine #(
  parameter int unsigned RP_CYCLES = udmab_pkg::RP_CYC,
  parameter int unsigned ZIORDY_CYCLES = udmab_pkg::ZIORDY_CYC,
  parameter int unsigned IORDYZ_CYCLES = udmab_pkg::IORDYZ_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic dmack_n_i,
  input wire logic stop_i,
  input wire logic hstrobe_i,
  input wire logic [15:0] data_i,
  output logic dmarq_o,
  output logic ddmardy_n_o,
  output logic ddmardy_oe_n_o,
  input wire logic xfer_req_i,
  input wire logic pause_i,
  input wire logic end_req_i,
  input wire logic cmd_start_i,
  output logic word_valid_o,
  output logic [15:0] word_o,
  output logic burst_done_o,
  output logic crc_err_o,
  output logic [15:0] err_host_crc_o,
  output logic [15:0] err_dev_crc_o
);
  localparam int unsigned CW = udmab_pkg::CNT_W;

  // The counters are CW bits wide, so longer waits cannot be served
  if (RP_CYCLES < 1 || RP_CYCLES > 255 || ZIORDY_CYCLES < 1 || ZIORDY_CYCLES > 255 ||
      IORDYZ_CYCLES < 1 || IORDYZ_CYCLES > 255) begin : g_bad_counts
    $error("udmab_engine: cycle counts must be 1..255");
  end

  // ****************************************
  // CRC function
  // ****************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ udmab_pkg::CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // ****************************************
  // Pin synchronisation
  // ****************************************
  udmab_pkg::udmab_host_t host_raw;
  udmab_pkg::udmab_host_t host_s;
  udmab_pkg::udmab_host_t host_idle;
  udmab_pkg::udmab_host_t host_d_r;

  assign host_raw = '{dmack_n: dmack_n_i, stop: stop_i, hstrobe: hstrobe_i, data: data_i};
  assign host_idle = '{dmack_n: 1'b1, stop: 1'b0, hstrobe: 1'b1, data: 16'h0000};

  // Data rides with the strobe; the host's setup and hold keep it steady around an edge
  udmab_sync #(.W($bits(udmab_pkg::udmab_host_t))) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(host_raw),
    .rst_val_i(host_idle),
    .sync_o(host_s)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_d_r <= '{dmack_n: 1'b1, stop: 1'b0, hstrobe: 1'b1, data: 16'h0000};
    end else begin
      host_d_r <= host_s;
    end
  end

  logic ack;
  logic ack_fall;
  logic strobe_edge;
  logic stop_fall;
  assign ack = !host_s.dmack_n;
  assign ack_fall = host_s.dmack_n && !host_d_r.dmack_n;
  assign strobe_edge = host_s.hstrobe != host_d_r.hstrobe;
  assign stop_fall = !host_s.stop && host_d_r.stop;

  // ****************************************
  // Burst state machine
  // ****************************************
  udmab_pkg::udmab_state_t state_r;
  logic [CW-1:0] cnt_r;
  logic first_seen_r;
  logic any_word_r;
  logic stop_seen_r;
  logic [15:0] crc_r;

  // Burst roles of STOP and HSTROBE count only while both handshakes stand. In a device
  // termination the request is already down, but edges launched before the host saw that
  // still come through the synchroniser and are real words.
  logic in_burst;
  assign in_burst = (dmarq_o || state_r == udmab_pkg::ST_TERM) && ack;
  // Edges under STOP are the strobe's return at termination and carry no data;
  // the first word is always a falling edge.
  logic data_edge;
  assign data_edge = in_burst && strobe_edge && !host_s.stop &&
    (first_seen_r || !host_s.hstrobe);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= udmab_pkg::ST_IDLE;
      cnt_r <= '0;
      dmarq_o <= 1'b0;
      ddmardy_n_o <= 1'b1;
      ddmardy_oe_n_o <= 1'b1;
      stop_seen_r <= 1'b0;
    end else begin
      case (state_r)
        udmab_pkg::ST_IDLE: begin
          ddmardy_oe_n_o <= 1'b1;
          ddmardy_n_o <= 1'b1;
          stop_seen_r <= 1'b0;
          if (xfer_req_i && !ack) begin
            dmarq_o <= 1'b1;
            cnt_r <= '0;
            state_r <= udmab_pkg::ST_REQ;
          end
        end
        udmab_pkg::ST_REQ: begin
          if (ack) begin
            if (cnt_r >= CW'(ZIORDY_CYCLES)) begin
              ddmardy_oe_n_o <= 1'b0;
              ddmardy_n_o <= 1'b1;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
            if (stop_fall) begin
              stop_seen_r <= 1'b1;
            end
            if ((stop_fall || stop_seen_r) && !ddmardy_oe_n_o) begin
              ddmardy_n_o <= 1'b0;
              state_r <= udmab_pkg::ST_XFER;
            end
          end
        end
        udmab_pkg::ST_XFER: begin
          if (ack_fall) begin
            state_r <= udmab_pkg::ST_DONE;
            cnt_r <= '0;
          end else if ((pause_i || end_req_i) && any_word_r) begin
            ddmardy_n_o <= 1'b1;
            cnt_r <= '0;
            state_r <= udmab_pkg::ST_PAUSE;
          end
        end
        udmab_pkg::ST_PAUSE: begin
          if (cnt_r < CW'(RP_CYCLES)) begin
            cnt_r <= cnt_r + 1'b1;
          end
          if (ack_fall) begin
            state_r <= udmab_pkg::ST_DONE;
            cnt_r <= '0;
          end else if (end_req_i && cnt_r >= CW'(RP_CYCLES)) begin
            dmarq_o <= 1'b0;
            state_r <= udmab_pkg::ST_TERM;
          end else if (!pause_i && !end_req_i) begin
            ddmardy_n_o <= 1'b0;
            state_r <= udmab_pkg::ST_XFER;
          end
        end
        udmab_pkg::ST_TERM: begin
          if (ack_fall) begin
            state_r <= udmab_pkg::ST_DONE;
            cnt_r <= '0;
          end
        end
        udmab_pkg::ST_DONE: begin
          dmarq_o <= 1'b0;
          ddmardy_n_o <= 1'b1;
          if (cnt_r + 1'b1 >= CW'(IORDYZ_CYCLES)) begin
            ddmardy_oe_n_o <= 1'b1;
            state_r <= udmab_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= udmab_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Word capture and CRC
  // ****************************************
  // No buffer is needed: every edge after a pause is still presented, so the
  // up to three trailing words are absorbed as they arrive.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_seen_r <= 1'b0;
      any_word_r <= 1'b0;
      crc_r <= udmab_pkg::CRC_SEED;
      word_valid_o <= 1'b0;
      word_o <= 16'h0000;
    end else begin
      word_valid_o <= 1'b0;
      if (state_r == udmab_pkg::ST_IDLE) begin
        first_seen_r <= 1'b0;
        any_word_r <= 1'b0;
        crc_r <= udmab_pkg::CRC_SEED;
      end else if (data_edge) begin
        first_seen_r <= 1'b1;
        any_word_r <= 1'b1;
        word_valid_o <= 1'b1;
        word_o <= host_s.data;
        crc_r <= crc_step(crc_r, host_s.data);
      end
    end
  end

  // ****************************************
  // Host CRC check and first-error report
  // ****************************************
  logic err_seen_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_seen_r <= 1'b0;
      crc_err_o <= 1'b0;
      err_host_crc_o <= 16'h0000;
      err_dev_crc_o <= 16'h0000;
      burst_done_o <= 1'b0;
    end else begin
      burst_done_o <= 1'b0;
      if (cmd_start_i) begin
        err_seen_r <= 1'b0;
        crc_err_o <= 1'b0;
      end
      // A miscompare in the cycle of a command start is kept: the set wins over the clear
      if (ack_fall && state_r != udmab_pkg::ST_IDLE) begin
        burst_done_o <= 1'b1;
        if (host_d_r.data != crc_r && (!err_seen_r || cmd_start_i)) begin
          err_seen_r <= 1'b1;
          crc_err_o <= 1'b1;
          err_host_crc_o <= host_d_r.data;
          err_dev_crc_o <= crc_r;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/udmab_engine_properties.sv */
// Port assertions for the burst engine
`timescale 1ns/1ps
`default_nettype none
module udmab_engine_chk #(
  parameter int unsigned RP_CYCLES = 4,
  parameter int unsigned ZIORDY_CYCLES = 1,
  parameter int unsigned IORDYZ_CYCLES = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic dmack_n_i,
  input wire logic stop_i,
  input wire logic hstrobe_i,
  input wire logic cmd_start_i,
  input wire logic dmarq_o,
  input wire logic ddmardy_n_o,
  input wire logic ddmardy_oe_n_o,
  input wire logic word_valid_o,
  input wire logic crc_err_o,
  input wire logic [15:0] err_host_crc_o
);
  logic fell_r;
  // ****
  // Strobe has fallen within this acknowledge
  // ****
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fell_r <= 1'b0;
    end else begin
      fell_r <= !dmack_n_i && (fell_r || !hstrobe_i);
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_req_when_idle: assert property ($rose(dmarq_o) |-> dmack_n_i)
    else $error("request raised under acknowledge");
  a_ready_drive_kept: assert property (
    !ddmardy_oe_n_o && !dmack_n_i |=> !ddmardy_oe_n_o) else $error("ready released early");
  a_ready_released: assert property (
    $rose(dmack_n_i) |-> ##[1:10] ddmardy_oe_n_o) else $error("ready not released");
  a_ready_on_stop: assert property (
    $fell(stop_i) && !dmack_n_i |-> ##[1:8] !ddmardy_n_o) else $error("ready late");
  a_ready_until_first: assert property (
    !ddmardy_n_o && !fell_r && !dmack_n_i |=> !ddmardy_n_o && dmarq_o)
    else $error("ready or request dropped before first word");
  a_word_per_edge: assert property (
    !dmack_n_i && !stop_i && $changed(hstrobe_i) && (fell_r || !hstrobe_i)
    |-> ##[2:7] word_valid_o) else $error("strobe edge gave no word");
  a_first_err_kept: assert property (
    crc_err_o && !cmd_start_i |=> crc_err_o && $stable(err_host_crc_o))
    else $error("first error record changed");
  a_drop_after_pause: assert property (
    $fell(dmarq_o) && !dmack_n_i |-> ddmardy_n_o && $past(ddmardy_n_o, RP_CYCLES + 1))
    else $error("request dropped too soon after pause");
endmodule
bind udmab_engine udmab_engine_chk #(.RP_CYCLES(RP_CYCLES), .ZIORDY_CYCLES(ZIORDY_CYCLES),
  .IORDYZ_CYCLES(IORDYZ_CYCLES)) i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .dmack_n_i(dmack_n_i), .stop_i(stop_i), .hstrobe_i(hstrobe_i), .cmd_start_i(cmd_start_i),
  .dmarq_o(dmarq_o), .ddmardy_n_o(ddmardy_n_o), .ddmardy_oe_n_o(ddmardy_oe_n_o),
  .word_valid_o(word_valid_o), .crc_err_o(crc_err_o), .err_host_crc_o(err_host_crc_o));
`default_nettype wire

/* tb/udmab_host_model.sv */
// Behavioural host controller for data-out bursts
`timescale 1ns/1ps
`default_nettype none
module udmab_host_model (
  input wire logic ref_clk_i,
  input wire logic dmarq_i,
  input wire logic ddmardy_n_i,
  input wire logic ddmardy_oe_n_i,
  input wire logic [15:0] bad_i,
  output var udmab_pkg::udmab_host_t host_o
);
  logic [15:0] tx_q[$];
  logic [15:0] crc;
  // Released ready line is pulled to its not-ready level
  wire logic rdy_n = ddmardy_oe_n_i | ddmardy_n_i;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? udmab_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic run_burst();
    crc = udmab_pkg::CRC_SEED;
    host_o.stop <= 1'b1;
    host_o.hstrobe <= 1'b1;
    tick(2);
    host_o.dmack_n <= 1'b0;
    tick(3);
    host_o.stop <= 1'b0;
    while (tx_q.size() > 0 && dmarq_i) begin
      if (rdy_n) begin
        tick(1);
      end else begin
        host_o.data <= tx_q[0];
        crc = crc_step(crc, tx_q.pop_front());
        tick(1);
        host_o.hstrobe <= ~host_o.hstrobe;
        tick(3);
      end
    end
    host_o.stop <= 1'b1;
    host_o.hstrobe <= 1'b1;
    host_o.data <= crc ^ bad_i;
    tick(3);
    host_o.dmack_n <= 1'b1;
    tick(4);
    host_o.stop <= 1'b0;
  endtask
  initial begin
    host_o = '{dmack_n: 1'b1, stop: 1'b0, hstrobe: 1'b1, data: 16'h0000};
    forever begin
      tick(1);
      // Idle bus keeps changing so a stale value is never mistaken for data
      host_o.data <= ~host_o.data;
      if (dmarq_i) begin
        run_burst();
        while (dmarq_i) tick(1);
      end
    end
  end
endmodule
`default_nettype wire

/* tb/test_ultra_dma_burst_engine.sv */
// Self-checking bench for the burst engine
`timescale 1ns/1ps
`default_nettype none
module test_ultra_dma_burst_engine;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic xfer_req_i = 1'b0;
  logic pause_i = 1'b0;
  logic end_req_i = 1'b0;
  logic cmd_start_i = 1'b0;
  logic [15:0] bad = 16'h0000;
  udmab_pkg::udmab_host_t host;
  logic dmarq_o, ddmardy_n_o, ddmardy_oe_n_o, word_valid_o, burst_done_o, crc_err_o;
  logic [15:0] word_o, err_host_crc_o, err_dev_crc_o, e_host, e_dev;
  logic e_flag = 1'b0;
  logic [15:0] exp_q[$], rx_q[$];
  int num_errors = 0, n_compared = 0, seed = 43158, cyc = 0, t;
  int n_done = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  udmab_engine i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .dmack_n_i(host.dmack_n),
    .stop_i(host.stop), .hstrobe_i(host.hstrobe), .data_i(host.data), .dmarq_o(dmarq_o),
    .ddmardy_n_o(ddmardy_n_o), .ddmardy_oe_n_o(ddmardy_oe_n_o), .xfer_req_i(xfer_req_i),
    .pause_i(pause_i), .end_req_i(end_req_i), .cmd_start_i(cmd_start_i),
    .word_valid_o(word_valid_o), .word_o(word_o), .burst_done_o(burst_done_o),
    .crc_err_o(crc_err_o), .err_host_crc_o(err_host_crc_o), .err_dev_crc_o(err_dev_crc_o));
  udmab_host_model i_host (.ref_clk_i(ref_clk_i), .dmarq_i(dmarq_o), .ddmardy_n_i(ddmardy_n_o),
    .ddmardy_oe_n_i(ddmardy_oe_n_o), .bad_i(bad), .host_o(host));
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (word_valid_o === 1'b1) rx_q.push_back(word_o);
    if (burst_done_o === 1'b1) n_done <= n_done + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Mode 0 plain, 1 pause after ps words, 2 end request after ps words
  task automatic burst(input int n, input int mode, input logic [15:0] msk);
    int k, ps, sent, d0;
    logic [15:0] crc;
    ps = 1 + $unsigned($random(seed)) % (n - 1);
    exp_q.delete();
    rx_q.delete();
    for (k = 0; k < n; k++) exp_q.push_back(16'($random(seed)));
    i_host.tx_q = exp_q;
    d0 = n_done;
    @(posedge ref_clk_i);
    bad <= msk;
    xfer_req_i <= 1'b1;
    for (k = 0; k < 20 && dmarq_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk("request", dmarq_o, 1'b1);
    @(posedge ref_clk_i);
    xfer_req_i <= 1'b0;
    if (mode > 0) begin
      for (k = 0; k < 400 && rx_q.size() < ps; k++) @(negedge ref_clk_i);
      @(posedge ref_clk_i);
      pause_i <= (mode == 1);
      end_req_i <= (mode == 2);
      repeat (12) @(negedge ref_clk_i);
      chk("ready in pause", ddmardy_n_o, 1'b1);
      chk("pause overrun", rx_q.size() <= ps + 3, 1'b1);
      @(posedge ref_clk_i);
      pause_i <= 1'b0;
    end
    // The end pulse may come while the pause checks still run, so it is counted
    for (k = 0; k < 2000 && n_done == d0; k++) @(negedge ref_clk_i);
    chk("burst end", 16'(n_done - d0), 16'h0001);
    @(posedge ref_clk_i);
    end_req_i <= 1'b0;
    repeat (4) @(negedge ref_clk_i);
    sent = n - i_host.tx_q.size();
    chk("word count", 16'(rx_q.size()), 16'(sent));
    crc = udmab_pkg::CRC_SEED;
    for (k = 0; k < sent; k++) begin
      chk("word", rx_q[k], exp_q[k]);
      crc = i_host.crc_step(crc, exp_q[k]);
    end
    if (msk != 16'h0000 && !e_flag) begin
      e_flag = 1'b1;
      e_host = crc ^ msk;
      e_dev = crc;
    end
    chk("crc error", crc_err_o, e_flag);
    if (e_flag) begin
      chk("host crc", err_host_crc_o, e_host);
      chk("device crc", err_dev_crc_o, e_dev);
    end
    i_host.tx_q.delete();
    $display("burst of %0d words, mode %0d, done", n, mode);
  endtask
  task automatic new_cmd();
    @(posedge ref_clk_i);
    cmd_start_i <= 1'b1;
    @(posedge ref_clk_i);
    cmd_start_i <= 1'b0;
    e_flag = 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(negedge ref_clk_i);
    chk("request at reset", dmarq_o, 1'b0);
    chk("ready enable at reset", ddmardy_oe_n_o, 1'b1);
    $display("reset test done");
    new_cmd();
    for (t = 0; t < 9; t++) burst(2 + $unsigned($random(seed)) % 5, t % 3, 16'h0000);
    burst(3, 0, 16'h0001);
    burst(2, 1, 16'h8000);
    new_cmd();
    burst(4, 0, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
